// [pkg/rcr_defines.vh]
// Constants for the reset cause and release block.
`ifndef RCR_DEFINES_VH
`define RCR_DEFINES_VH
`define RCR_ADDR_CAUSE    12'h000
`define RCR_ADDR_CFG      12'h004
`define RCR_ADDR_STAT     12'h008
`define RCR_BIT_TRAP      15
`define RCR_BIT_ILLOP     14
`define RCR_BIT_SBOR      13
`define RCR_BIT_LVS       12
`define RCR_BIT_DSLP      10
`define RCR_BIT_CFGMM     9
`define RCR_BIT_PROGMEM_SLEEP_POWER     8
`define RCR_BIT_PIN       7
`define RCR_BIT_SOFT      6
`define RCR_BIT_SWDT      5
`define RCR_BIT_WATCHDOG_TIMEOUT_FLAG      4
`define RCR_BIT_SLEEP     3
`define RCR_BIT_IDLE      2
`define RCR_BIT_BOR       1
`define RCR_BIT_POR       0
`define RCR_CAUSE_RESET   16'h0003
`define RCR_CAUSE_MASK    16'hF7FF
`define RCR_BORMODE_SOFT  2'h1
`define RCR_POWERUP_TIMER_MS       64
`define RCR_POR_US        2
`define RCR_CLK_MHZ       20
`define RCR_OST_PERIODS   1024
`define RCR_LOCK_US       2
`define RCR_CFG_RESET     3'h0
`endif

// [logic/rcr_top.v]
// Reset cause recording, reset clock selection and system reset release timing.
// Behaviour
// [RL1] Trap conflict sets bit 15; POR clears.
// [RL2] Illegal operation sets bit 14; POR clears.
// [RL3] Config mismatch sets bit 9; POR clears.
// [RL4] Master clear pin sets bit 7.
// [RL5] Reset instruction sets bit 6.
// [RL6] Watchdog timeout bit 4; power-save clears.
// [RL7] Sleep bit 3, idle bit 2 set.
// [RL8] Brown-out flag set by BOR and POR.
// [RL9] Power-on flag set by POR, resets one.
// [RL10] Deep sleep flag when sleep with enable.
// [RL11] Software writes flags; never causes reset.
// [RL12] Bit 13 turns brown-out detection on/off.
// [RL13] Bit 12 selects low-voltage sleep regulator.
// [RL14] Bit 8 keeps progmem bias in sleep.
// [RL15] Watchdog on by bit 5 or config.
// [RL16] Reset clock source chosen by reset type.
// [RL17] Release after POR+POWERUP_TIMER, POWERUP_TIMER, or none.
// [RL18] Power-up delay 64 ms or zero.
// [RL19] Start-up timer counts 1024 oscillator periods.
// [RL20] Oscillator waits run alongside release delay.
// [RL21] No execution before valid clock delivered.
// [RL22] Two-speed start uses fast RC after POR.
// [RL23] Any active source asserts system reset.
// [RL24] POR clears all but BOR, POR flags.
// [RL25] Software brown-out enable only in mode 01.
// [RL26] New source restarts release delay counters.
`include "rcr_defines.vh"
`timescale 1ns/1ns
`default_nettype none
module rcr_top #(
  parameter [31:0] POWERUP_TIMER_CYC = `RCR_POWERUP_TIMER_MS * 1000 * `RCR_CLK_MHZ,
  parameter [31:0] POR_CYC  = `RCR_POR_US * `RCR_CLK_MHZ,
  parameter [31:0] LOCK_CYC = `RCR_LOCK_US * `RCR_CLK_MHZ
) (
  input  wire        SYS_CLK,
  input  wire        RST_N,
  input  wire        HSEL,
  input  wire [31:0] HADDR,
  input  wire [1:0]  HTRANS,
  input  wire        HWRITE,
  input  wire [2:0]  HSIZE,
  input  wire        HREADY,
  input  wire [31:0] HWDATA,
  output reg  [31:0] HRDATA,
  output reg         HREADYOUT,
  output reg         HRESP,
  input  wire        POR_EVT,
  input  wire        BOR_EVT,
  input  wire        PIN_EVT,
  input  wire        SOFT_EVT,
  input  wire        WDT_EVT,
  input  wire        TRAP_EVT,
  input  wire        ILLOP_EVT,
  input  wire        CFGMM_EVT,
  input  wire        POWER_SAVE_INSTR_SLEEP,
  input  wire        POWER_SAVE_INSTR_IDLE,
  input  wire        DEEP_SLEEP_EN,
  input  wire [1:0]  BROWNOUT_MODE_CFG,
  input  wire        WATCHDOG_CFG_ENABLE,
  input  wire        POWERUP_TIMER_CFG_EN,
  input  wire        CLK_SWITCH_EN,
  input  wire        TWO_SPEED_EN,
  input  wire [2:0]  NEW_OSC_SELECT_CFG,
  input  wire [2:0]  CURRENT_OSC_FIELD,
  input  wire        OSC_TICK,
  input  wire        OSC_IS_CRYSTAL,
  input  wire        OSC_USES_PLL,
  output reg         SYSTEM_RESET,
  output reg         CPU_RUN,
  output reg  [2:0]  RESET_OSC_SEL,
  output reg         USE_FAST_RC,
  output reg         BROWNOUT_DET_EN,
  output reg         LOW_VOLT_SLEEP,
  output reg         PROGMEM_SLEEP_PWR,
  output reg         WATCHDOG_EN
);

  localparam [3:0] ST_RUN  = 4'b0001;
  localparam [3:0] ST_POR  = 4'b0010;
  localparam [3:0] ST_POWERUP_TIMER = 4'b0100;
  localparam [3:0] ST_CLKW = 4'b1000;

  ////////////////////////////////////////////////////////////////////////////
  // Bus slave: every access completes with no wait state.
  reg        wr_pend_r;
  reg        rd_pend_r;
  reg [11:0] addr_r;
  reg [15:0] cause_r;
  reg [2:0]  cfg_r;
  reg [3:0]  st_r;
  reg [31:0] dly_r;
  reg [9:0]  ost_r;
  reg [31:0] lock_r;
  reg        osc_ok_r;
  reg [31:0] rdata_nxt;
  wire [15:0] cause_nxt;

  wire take = HSEL && HREADY && HTRANS[1];
  wire wr_cause = wr_pend_r && (addr_r == `RCR_ADDR_CAUSE);
  wire wr_cfg = wr_pend_r && (addr_r == `RCR_ADDR_CFG);
  wire sbor_ok = (BROWNOUT_MODE_CFG == `RCR_BORMODE_SOFT);

  wire any_src = POR_EVT | BOR_EVT | PIN_EVT | SOFT_EVT | WDT_EVT |
                 TRAP_EVT | ILLOP_EVT | CFGMM_EVT; // [RL23]
  wire powerup_timer_zero = !POWERUP_TIMER_CFG_EN || (POWERUP_TIMER_CYC == 32'h0); // [RL18]

  always @(posedge SYS_CLK) begin
    if (!RST_N) begin
      wr_pend_r <= 1'b0;
      rd_pend_r <= 1'b0;
      addr_r    <= 12'h000;
      HREADYOUT <= 1'b1;
      HRESP     <= 1'b0;
      HRDATA    <= 32'h0;
    end else begin
      wr_pend_r <= take && HWRITE;
      rd_pend_r <= take && !HWRITE;
      if (take) begin
        addr_r <= HADDR[11:0];
      end
      HREADYOUT <= 1'b1;
      HRESP     <= 1'b0;
      if (take && !HWRITE) begin
        HRDATA <= rdata_nxt;
      end
    end
  end

  // Read data. The cause word includes this cycle's hardware sets, so a flag
  // raised during the address phase is not missed by the read.
  always @* begin
    rdata_nxt = 32'h0;
    if (HADDR[11:0] == `RCR_ADDR_CAUSE) begin
      rdata_nxt = {16'h0, cause_nxt & `RCR_CAUSE_MASK};
    end else if (HADDR[11:0] == `RCR_ADDR_CFG) begin
      rdata_nxt = {29'h0, cfg_r};
    end else if (HADDR[11:0] == `RCR_ADDR_STAT) begin
      rdata_nxt = {26'h0, osc_ok_r, st_r, CPU_RUN};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Cause register. Hardware sets take priority over a software write in the
  // same cycle so a reset event is never lost.
  wire [15:0] wr_val   = HWDATA[15:0] & `RCR_CAUSE_MASK;
  wire        psave    = POWER_SAVE_INSTR_SLEEP || POWER_SAVE_INSTR_IDLE;
  wire [15:0] clr_vec  = {15'h0000, psave} << `RCR_BIT_WATCHDOG_TIMEOUT_FLAG; // [RL6]
  wire [15:0] keep_vec = sbor_ok ? 16'hFFFF : ~(16'h0001 << `RCR_BIT_SBOR); // [RL25]
  wire [15:0] set_vec  =
    ({15'h0000, TRAP_EVT} << `RCR_BIT_TRAP) | // [RL1]
    ({15'h0000, ILLOP_EVT} << `RCR_BIT_ILLOP) | // [RL2]
    ({15'h0000, CFGMM_EVT} << `RCR_BIT_CFGMM) | // [RL3]
    ({15'h0000, PIN_EVT} << `RCR_BIT_PIN) | // [RL4]
    ({15'h0000, SOFT_EVT} << `RCR_BIT_SOFT) | // [RL5]
    ({15'h0000, WDT_EVT} << `RCR_BIT_WATCHDOG_TIMEOUT_FLAG) | // [RL6]
    ({15'h0000, POWER_SAVE_INSTR_SLEEP} << `RCR_BIT_SLEEP) | // [RL7]
    ({15'h0000, POWER_SAVE_INSTR_IDLE} << `RCR_BIT_IDLE) | // [RL7]
    ({15'h0000, POWER_SAVE_INSTR_SLEEP && DEEP_SLEEP_EN} << `RCR_BIT_DSLP) | // [RL10]
    ({15'h0000, BOR_EVT} << `RCR_BIT_BOR); // [RL8]
  wire [15:0] por_val  = `RCR_CAUSE_RESET;

  genvar gi;
  generate
    for (gi = 0; gi < 16; gi = gi + 1) begin : g_cause
      wire base_bit = wr_cause ? wr_val[gi] : cause_r[gi]; // [RL11]
      wire hold_bit = base_bit && !clr_vec[gi] && keep_vec[gi];
      // A power-on event wins over every other source and over software.
      assign cause_nxt[gi] = POR_EVT ? por_val[gi] : (set_vec[gi] || hold_bit); // [RL24] [RL9]
    end
  endgenerate

  always @(posedge SYS_CLK) begin
    if (!RST_N) begin
      cause_r <= `RCR_CAUSE_RESET; // [RL9]
      cfg_r   <= `RCR_CFG_RESET;
    end else begin
      cause_r <= cause_nxt;
      if (wr_cfg) begin
        cfg_r <= HWDATA[2:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control outputs driven by the cause register, and by the brown-out mode and watchdog config inputs.
  always @(posedge SYS_CLK) begin
    if (!RST_N) begin
      BROWNOUT_DET_EN   <= 1'b0;
      LOW_VOLT_SLEEP    <= 1'b0;
      PROGMEM_SLEEP_PWR <= 1'b0;
      WATCHDOG_EN       <= 1'b0;
    end else begin
      if (sbor_ok) begin
        BROWNOUT_DET_EN <= cause_r[`RCR_BIT_SBOR]; // [RL12] [RL25]
      end else begin
        BROWNOUT_DET_EN <= (BROWNOUT_MODE_CFG != 2'h0);
      end
      LOW_VOLT_SLEEP    <= cause_r[`RCR_BIT_LVS]; // [RL13]
      PROGMEM_SLEEP_PWR <= cause_r[`RCR_BIT_PROGMEM_SLEEP_POWER]; // [RL14]
      WATCHDOG_EN <= WATCHDOG_CFG_ENABLE | cause_r[`RCR_BIT_SWDT]; // [RL15]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Release sequencer. The oscillator waits run in parallel with the delays,
  // so a slow crystal can still hold execution after the system reset lets go.
  reg [3:0]  st_nxt;
  reg [31:0] dly_nxt;
  reg [9:0]  ost_nxt;
  reg [31:0] lock_nxt;
  reg        osc_ok_nxt;
  reg        sys_rst_nxt;
  reg        cpu_run_nxt;
  reg [2:0]  osc_sel_nxt;
  reg        fast_rc_nxt;

  wire ost_done  = !OSC_IS_CRYSTAL || (ost_r == 10'h3FF && OSC_TICK);
  wire lock_done = !OSC_USES_PLL || (lock_r >= LOCK_CYC);
  wire por_last  = (dly_r + 32'h1 >= POR_CYC);
  wire powerup_timer_last = powerup_timer_zero || (dly_r + 32'h1 >= POWERUP_TIMER_CYC); // [RL18]

  // Oscillator wait counters. A fresh source throws away any progress, since
  // the oscillator may have been disturbed by whatever caused the reset.
  always @* begin
    ost_nxt    = ost_r;
    lock_nxt   = lock_r;
    osc_ok_nxt = osc_ok_r;
    if (any_src) begin
      ost_nxt    = 10'h000; // [RL26]
      lock_nxt   = 32'h0; // [RL26]
      osc_ok_nxt = 1'b0;
    end else if (!osc_ok_r) begin
      if (OSC_IS_CRYSTAL && OSC_TICK && !ost_done) begin
        ost_nxt = ost_r + 10'h001; // [RL19] [RL20]
      end
      if (OSC_USES_PLL && !lock_done) begin
        lock_nxt = lock_r + 32'h1; // [RL20]
      end
      osc_ok_nxt = (ost_done || USE_FAST_RC) && lock_done;
    end
  end

  // Release state machine. Once the valid clock is seen it stays valid until
  // the next source, so a late oscillator glitch cannot stop execution.
  always @* begin
    st_nxt      = st_r;
    dly_nxt     = dly_r;
    sys_rst_nxt = SYSTEM_RESET;
    cpu_run_nxt = CPU_RUN;
    osc_sel_nxt = RESET_OSC_SEL;
    fast_rc_nxt = USE_FAST_RC;
    if (any_src) begin
      dly_nxt     = 32'h0; // [RL26]
      sys_rst_nxt = 1'b1; // [RL23]
      cpu_run_nxt = 1'b0;
      if (!CLK_SWITCH_EN || POR_EVT || BOR_EVT) begin
        osc_sel_nxt = NEW_OSC_SELECT_CFG; // [RL16]
      end else begin
        osc_sel_nxt = CURRENT_OSC_FIELD; // [RL16]
      end
      fast_rc_nxt = POR_EVT && TWO_SPEED_EN; // [RL22]
      if (POR_EVT) begin
        st_nxt = ST_POR; // [RL17]
      end else if (BOR_EVT) begin
        st_nxt = ST_POWERUP_TIMER; // [RL17]
      end else begin
        st_nxt = ST_CLKW; // [RL17]
      end
    end else begin
      case (st_r)
        ST_POR: begin
          // A power-on start, from a source or from the reset pin, always
          // takes the configured oscillator.
          osc_sel_nxt = NEW_OSC_SELECT_CFG; // [RL16]
          fast_rc_nxt = TWO_SPEED_EN; // [RL22]
          if (por_last) begin
            dly_nxt = 32'h0;
            st_nxt  = ST_POWERUP_TIMER;
          end else begin
            dly_nxt = dly_r + 32'h1;
          end
        end
        ST_POWERUP_TIMER: begin
          if (powerup_timer_last) begin
            dly_nxt     = 32'h0;
            st_nxt      = ST_CLKW;
            sys_rst_nxt = 1'b0; // [RL17]
          end else begin
            dly_nxt = dly_r + 32'h1; // [RL18]
          end
        end
        ST_CLKW: begin
          sys_rst_nxt = 1'b0;
          if (!SYSTEM_RESET && osc_ok_r) begin
            st_nxt      = ST_RUN;
            cpu_run_nxt = 1'b1; // [RL21]
          end
        end
        ST_RUN: begin
          cpu_run_nxt = 1'b1;
        end
        default: begin
          st_nxt = ST_POR;
        end
      endcase
    end
  end

  // Sequencer registers. Reset lands in the power-on delay state.
  always @(posedge SYS_CLK) begin
    if (!RST_N) begin
      st_r          <= ST_POR;
      dly_r         <= 32'h0;
      ost_r         <= 10'h000;
      lock_r        <= 32'h0;
      osc_ok_r      <= 1'b0;
      SYSTEM_RESET  <= 1'b1;
      CPU_RUN       <= 1'b0;
      RESET_OSC_SEL <= 3'h0;
      USE_FAST_RC   <= 1'b0;
    end else begin
      st_r          <= st_nxt;
      dly_r         <= dly_nxt;
      ost_r         <= ost_nxt;
      lock_r        <= lock_nxt;
      osc_ok_r      <= osc_ok_nxt;
      SYSTEM_RESET  <= sys_rst_nxt;
      CPU_RUN       <= cpu_run_nxt;
      RESET_OSC_SEL <= osc_sel_nxt;
      USE_FAST_RC   <= fast_rc_nxt;
    end
  end

endmodule // rcr_top
`default_nettype wire

// [verification/rcr_chk_checker.sv]
// Concurrent checks on the reset sequencer ports.
`timescale 1ns/1ns
`default_nettype none
module rcr_chk (
  input wire logic       SYS_CLK,
  input wire logic       RST_N,
  input wire logic       POR_EVT,
  input wire logic       BOR_EVT,
  input wire logic       PIN_EVT,
  input wire logic       SOFT_EVT,
  input wire logic       WDT_EVT,
  input wire logic       TRAP_EVT,
  input wire logic       ILLOP_EVT,
  input wire logic       CFGMM_EVT,
  input wire logic       SYSTEM_RESET,
  input wire logic       CPU_RUN,
  input wire logic       WATCHDOG_CFG_ENABLE,
  input wire logic       WATCHDOG_EN,
  input wire logic [1:0] BROWNOUT_MODE_CFG,
  input wire logic       BROWNOUT_DET_EN,
  input wire logic       CLK_SWITCH_EN,
  input wire logic [2:0] NEW_OSC_SELECT_CFG,
  input wire logic [2:0] RESET_OSC_SEL
);
  wire any_src = POR_EVT | BOR_EVT | PIN_EVT | SOFT_EVT | WDT_EVT | TRAP_EVT | ILLOP_EVT | CFGMM_EVT;
  default clocking cb @(posedge SYS_CLK);
  endclocking
  default disable iff (!RST_N);
  // A pin reset from a quiet system must not borrow the power-up delays.
  sequence s_pin;
    !SYSTEM_RESET ##1 (PIN_EVT && !POR_EVT && !BOR_EVT) ##1 (!any_src) [*3];
  endsequence
  property p_src; any_src |=> SYSTEM_RESET; endproperty
  a_src: assert property (p_src) else $error("source left reset low");
  property p_run; CPU_RUN |-> !SYSTEM_RESET; endproperty
  a_run: assert property (p_run) else $error("running under reset");
  property p_rise; $rose(CPU_RUN) |-> !$past(SYSTEM_RESET); endproperty
  a_rise: assert property (p_rise) else $error("run rose with reset");
  property p_por; $fell(POR_EVT) |-> SYSTEM_RESET [*3]; endproperty
  a_por: assert property (p_por) else $error("power-on delay skipped");
  property p_pin; s_pin |-> !SYSTEM_RESET; endproperty
  a_pin: assert property (p_pin) else $error("pin reset delayed");
  property p_wdt; WATCHDOG_CFG_ENABLE [*3] |-> WATCHDOG_EN; endproperty
  a_wdt: assert property (p_wdt) else $error("watchdog not forced on");
  property p_bor; (BROWNOUT_MODE_CFG == 2'h0) [*3] |-> !BROWNOUT_DET_EN; endproperty
  a_bor: assert property (p_bor) else $error("brown-out on in mode 0");
  property p_osc;
    $fell(SYSTEM_RESET) && !CLK_SWITCH_EN |-> RESET_OSC_SEL == NEW_OSC_SELECT_CFG;
  endproperty
  a_osc: assert property (p_osc) else $error("wrong reset clock");
endmodule // rcr_chk
bind rcr_top rcr_chk i_rcr_chk (.*);
`default_nettype wire

// [verification/tb_top.sv]
// Self-checking bench for the reset cause and release block.
`timescale 1ns/1ns
`default_nettype none
`include "rcr_defines.vh"
`define CK(a, b) begin cmp_count++; if ((a) !== (b)) begin n_mismatch++; $display("mismatch %0t got %h exp %h", $time, a, b); end end
module tb_top;
  localparam int PW = 20;
  localparam int PO = 4;
  logic SYS_CLK = 0, RST_N = 0, HSEL = 0, HWRITE = 0, POWER_SAVE_INSTR_SLEEP = 0, POWER_SAVE_INSTR_IDLE = 0;
  logic DEEP_SLEEP_EN = 0, WATCHDOG_CFG_ENABLE = 0, POWERUP_TIMER_CFG_EN = 1, CLK_SWITCH_EN = 0;
  logic TWO_SPEED_EN = 0, OSC_TICK = 0, OSC_IS_CRYSTAL = 0, OSC_USES_PLL = 0;
  logic [1:0]  HTRANS = 0, BROWNOUT_MODE_CFG = 2'h3;
  logic [2:0]  HSIZE = 3'h2, NEW_OSC_SELECT_CFG = 3'h5, CURRENT_OSC_FIELD = 3'h2;
  logic [31:0] HADDR = 0, HWDATA = 0, rd;
  logic [7:0]  ev = 0;
  wire HREADY, HREADYOUT, HRESP, SYSTEM_RESET, CPU_RUN, USE_FAST_RC, BROWNOUT_DET_EN;
  wire LOW_VOLT_SLEEP, PROGMEM_SLEEP_PWR, WATCHDOG_EN;
  wire POR_EVT, BOR_EVT, PIN_EVT, SOFT_EVT, WDT_EVT, TRAP_EVT, ILLOP_EVT, CFGMM_EVT;
  wire [31:0] HRDATA;
  wire [2:0]  RESET_OSC_SEL;
  int n_mismatch = 0, cmp_count = 0, n;
  assign HREADY = HREADYOUT;
  assign {CFGMM_EVT, ILLOP_EVT, TRAP_EVT, WDT_EVT, SOFT_EVT, PIN_EVT, BOR_EVT, POR_EVT} = ev;
  rcr_top #(.POWERUP_TIMER_CYC(PW), .POR_CYC(PO), .LOCK_CYC(4)) i_rcr_top (.*);
  initial forever #25 SYS_CLK = ~SYS_CLK;
  ////////////////////////////////////////////////////////////////
  task automatic bus(input logic w, input logic [11:0] a, input logic [15:0] d);
    @(posedge SYS_CLK);
    HSEL <= 1'b1;
    HTRANS <= 2'h2;
    HADDR <= {20'h0, a};
    HWRITE <= w;
    @(posedge SYS_CLK iff HREADY);
    HSEL <= 1'b0;
    HTRANS <= 2'h0;
    HWDATA <= {16'h0, d};
    @(posedge SYS_CLK iff HREADY);
    rd = HRDATA;
    `CK({HREADYOUT, HRESP}, 2'h2)
  endtask
  // Pulses one reset source and counts edges until the system reset lets go.
  task automatic src(input int i);
    @(posedge SYS_CLK);
    ev <= 8'(1 << i);
    @(posedge SYS_CLK);
    ev <= 8'h00;
    n = 0;
    do begin
      @(posedge SYS_CLK);
      n++;
    end while (SYSTEM_RESET !== 1'b0 && n < 3000);
  endtask
  task automatic wrun;
    while (CPU_RUN !== 1'b1 && n < 3000) begin
      @(posedge SYS_CLK);
      n++;
    end
  endtask
  task automatic ps(input logic s);
    @(posedge SYS_CLK);
    POWER_SAVE_INSTR_SLEEP <= s;
    POWER_SAVE_INSTR_IDLE <= !s;
    @(posedge SYS_CLK);
    POWER_SAVE_INSTR_SLEEP <= 1'b0;
    POWER_SAVE_INSTR_IDLE <= 1'b0;
  endtask
  ////////////////////////////////////////////////////////////////
  task automatic t_por;
    src(0);
    `CK(n >= PO + PW && n <= PO + PW + 3, 1'b1)
    bus(0, `RCR_ADDR_CAUSE, 16'h0);
    `CK(rd[15:0], `RCR_CAUSE_RESET)
    POWERUP_TIMER_CFG_EN <= 1'b0;
    src(0);
    `CK(n >= PO && n <= PO + 3, 1'b1)
    POWERUP_TIMER_CFG_EN <= 1'b1;
    $display("t_por done");
  endtask
  task automatic t_flags;
    int bits [7] = '{1, 7, 6, 4, 15, 14, 9};
    for (int i = 1; i < 8; i++) begin
      bus(1, `RCR_ADDR_CAUSE, 16'h0);
      src(i);
      if (i == 1) `CK(n >= PW && n <= PW + 3, 1'b1) else `CK(n <= 3, 1'b1)
      bus(0, `RCR_ADDR_CAUSE, 16'h0);
      `CK(rd[15:0], 16'(1 << bits[i-1]))
    end
    $display("t_flags done");
  endtask
  task automatic t_psave;
    bus(1, `RCR_ADDR_CAUSE, 16'hC6D0);
    bus(0, `RCR_ADDR_CAUSE, 16'h0);
    `CK(rd[15:0], 16'hC6D0)
    `CK(SYSTEM_RESET, 1'b0)
    bus(1, `RCR_ADDR_CAUSE, 16'h0010);
    DEEP_SLEEP_EN <= 1'b1;
    ps(1'b1);
    bus(0, `RCR_ADDR_CAUSE, 16'h0);
    `CK(rd[15:0], 16'h0408)
    DEEP_SLEEP_EN <= 1'b0;
    ps(1'b0);
    bus(0, `RCR_ADDR_CAUSE, 16'h0);
    `CK(rd[15:0], 16'h040C)
    src(0);
    bus(0, `RCR_ADDR_CAUSE, 16'h0);
    `CK(rd[15:0], `RCR_CAUSE_RESET)
    $display("t_psave done");
  endtask
  task automatic t_ctrl;
    BROWNOUT_MODE_CFG <= `RCR_BORMODE_SOFT;
    bus(1, `RCR_ADDR_CAUSE, 16'h3120);
    bus(0, `RCR_ADDR_CAUSE, 16'h0);
    `CK(rd[15:0], 16'h3120)
    `CK({BROWNOUT_DET_EN, LOW_VOLT_SLEEP, PROGMEM_SLEEP_PWR, WATCHDOG_EN}, 4'hF)
    WATCHDOG_CFG_ENABLE <= 1'b1;
    bus(1, `RCR_ADDR_CAUSE, 16'h0);
    bus(0, 12'h010, 16'h0);
    `CK(rd, 32'h0)
    `CK({BROWNOUT_DET_EN, LOW_VOLT_SLEEP, PROGMEM_SLEEP_PWR, WATCHDOG_EN}, 4'h1)
    WATCHDOG_CFG_ENABLE <= 1'b0;
    BROWNOUT_MODE_CFG <= 2'h2;
    bus(1, `RCR_ADDR_CAUSE, 16'h2000);
    bus(0, `RCR_ADDR_CAUSE, 16'h0);
    `CK(rd[13], 1'b0)
    `CK(BROWNOUT_DET_EN, 1'b1)
    BROWNOUT_MODE_CFG <= 2'h0;
    bus(0, `RCR_ADDR_CAUSE, 16'h0);
    `CK(BROWNOUT_DET_EN, 1'b0)
    BROWNOUT_MODE_CFG <= 2'h3;
    $display("t_ctrl done");
  endtask
  task automatic t_osc;
    CLK_SWITCH_EN <= 1'b1;
    src(0);
    `CK(RESET_OSC_SEL, 3'h5)
    src(2);
    `CK(RESET_OSC_SEL, 3'h2)
    CLK_SWITCH_EN <= 1'b0;
    src(2);
    `CK(RESET_OSC_SEL, 3'h5)
    OSC_IS_CRYSTAL <= 1'b1;
    OSC_TICK <= 1'b1;
    src(0);
    `CK(CPU_RUN, 1'b0)
    wrun;
    `CK(n >= 1020 && n <= 1030, 1'b1)
    TWO_SPEED_EN <= 1'b1;
    src(0);
    n = 0;
    wrun;
    `CK(USE_FAST_RC, 1'b1)
    `CK(n <= 4, 1'b1)
    TWO_SPEED_EN <= 1'b0;
    OSC_IS_CRYSTAL <= 1'b0;
    OSC_USES_PLL <= 1'b1;
    src(2);
    `CK(CPU_RUN, 1'b0)
    wrun;
    `CK(n >= 5 && n <= 8, 1'b1)
    OSC_USES_PLL <= 1'b0;
    $display("t_osc done");
  endtask
  task automatic finish_test;
    $display("counts: %0d mismatches, %0d compares", n_mismatch, cmp_count);
    if (n_mismatch == 0 && cmp_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  initial begin
    repeat (4) @(posedge SYS_CLK);
    RST_N <= 1'b1;
    repeat (PO + PW + 4) @(posedge SYS_CLK);
    t_por;
    t_flags;
    t_psave;
    t_ctrl;
    t_osc;
    finish_test;
  end
  // The run needs about thirteen hundred cycles; this leaves ample margin.
  initial begin
    #1000000;
    n_mismatch++;
    finish_test;
  end
endmodule // tb_top
`default_nettype wire
